// *** rtl/acc_msg_device.sv ***
// Purpose: sensor-side command interpreter and reply framer
// Assumes: link pins are asynchronous; sampled by two flip-flops each
// Notes: reply is snapshot at select; commands act at deselect
`timescale 1ns/1ps

// Contract
// [R01] host sends six bytes, checksum last
// [R02] command MSB first; bits 7,5,4 zero
// [R03] selector 0001 accel, 0010 status; others reserved
// [R04] host sends four zero data bytes
// [R05] command bit 6 requests self-test; status bit 3
// [R06] reply: status, four data, checksum
// [R07] two's complement words, high byte first
// [R08] reply content follows requested type
// [R09] status bit 4 flags previous bad checksum
// [R10] status bits 2:0 give reply type
// [R11] status bits 7,6,5 flag test failures
// [R12] checksum is inverted five-byte sum
// [R13] bad checksum: ignore, flag, keep type
// [R14] accel type after reset until valid command
// [R15] accel data: Y high, Y low, X high, X low
module acc_msg_device
(
  input wire logic clock, // system clock
  input wire logic rst, // asynchronous reset, active high
  acc_link_if.dev link, // serial link pins
  input wire logic [15:0] acc_y, // Y acceleration, two's complement
  input wire logic [15:0] acc_x, // X acceleration, two's complement
  input wire logic [15:0] temp, // temperature, two's complement
  input wire logic [7:0] stat_aux, // first data byte of status replies
  input wire logic bit_fail, // overall built-in test failed
  input wire logic y_fail, // Y channel failed
  input wire logic x_fail, // X channel failed
  output logic cbit_en, // self-test requested
  output logic [2:0] reply_type, // type chosen for the next reply
  output logic frame_ok, // pulse: good frame accepted
  output logic frame_bad, // pulse: frame failed checksum
  output logic frame_short // pulse: deselect with fewer than 48 bits
);

  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic ss_m;
    logic ss_s;
    logic ss_p;
    logic mosi_m;
    logic mosi_s;
    logic [acc_pkg::BITCNT_W-1:0] bits;
    logic [acc_pkg::FRAME_BITS-1:0] rx;
    logic [acc_pkg::FRAME_BITS-1:0] tx;
    logic miso;
    logic [2:0] rtype;
    logic cbit;
    logic cks_err;
    logic ok;
    logic bad;
    logic short_f;
  } state_t;

  localparam state_t STATE_RST = '{
    ss_m: 1'b1,
    ss_s: 1'b1,
    ss_p: 1'b1,
    rtype: acc_pkg::TYPE_ACC,
    default: '0
  };

  state_t state_q;
  state_t state_d;

  logic rise;
  logic fall;
  logic sel;
  logic start_ev;
  logic stop_ev;
  logic [7:0] status_b;
  logic [31:0] data_w;
  logic [39:0] body_w;
  logic [acc_pkg::FRAME_BITS-1:0] reply_w;
  logic [7:0] cmd_w;
  logic [3:0] cmd_sel;
  logic good_cks;
  logic cmd_legal;
  logic [2:0] cmd_type;

  assign rise = state_q.sclk_s & ~state_q.sclk_p;
  assign fall = ~state_q.sclk_s & state_q.sclk_p;
  assign sel = ~state_q.ss_s;
  assign start_ev = ~state_q.ss_s & state_q.ss_p;
  assign stop_ev = state_q.ss_s & ~state_q.ss_p;

  // status byte of the outgoing reply
  always_comb
  begin
    status_b = acc_pkg::ZERO_BYTE;
    status_b[acc_pkg::ST_BIT_FAIL] = bit_fail; // see [R11]
    status_b[acc_pkg::ST_Y_FAIL] = y_fail; // see [R11]
    status_b[acc_pkg::ST_X_FAIL] = x_fail; // see [R11]
    status_b[acc_pkg::ST_CKS_ERR] = state_q.cks_err; // see [R09]
    status_b[acc_pkg::ST_CBIT] = state_q.cbit; // see [R05]
    status_b[acc_pkg::TYPE_MSB:0] = state_q.rtype; // see [R10]
  end

  // data bytes chosen by the last accepted type
  always_comb
  begin
    if (state_q.rtype == acc_pkg::TYPE_STAT) // see [R08]
    begin
      data_w = {stat_aux, acc_pkg::ZERO_BYTE, temp}; // see [R07]
    end
    else
    begin
      data_w = {acc_y, acc_x}; // see [R15] and [R07]
    end
  end

  // status first, then data, checksum last
  assign body_w = {status_b, data_w};
  assign reply_w = {body_w, acc_pkg::frame_cks(body_w)}; // see [R06] [R12]

  // decode of the received command byte
  assign cmd_w = state_q.rx[acc_pkg::FRAME_BITS-1 -: 8]; // see [R02]
  assign cmd_sel = cmd_w[acc_pkg::SEL_MSB:0];
  assign good_cks = acc_pkg::frame_cks(state_q.rx[47:8]) ==
    state_q.rx[7:0]; // see [R12]

  always_comb
  begin
    cmd_legal = ~cmd_w[acc_pkg::CMD_RSVD7] & ~cmd_w[acc_pkg::CMD_RSVD5] &
      ~cmd_w[acc_pkg::CMD_RSVD4]; // see [R02]
    cmd_type = acc_pkg::TYPE_ACC;
    case (cmd_sel) // see [R03]
      acc_pkg::SEL_ACC:
      begin
        cmd_type = acc_pkg::TYPE_ACC;
      end
      acc_pkg::SEL_STAT:
      begin
        cmd_type = acc_pkg::TYPE_STAT;
      end
      default:
      begin
        cmd_legal = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    state_d.sclk_m = link.sclk;
    state_d.sclk_s = state_q.sclk_m;
    state_d.sclk_p = state_q.sclk_s;
    state_d.ss_m = link.ss_n;
    state_d.ss_s = state_q.ss_m;
    state_d.ss_p = state_q.ss_s;
    state_d.mosi_m = link.mosi;
    state_d.mosi_s = state_q.mosi_m;
    state_d.ok = 1'b0;
    state_d.bad = 1'b0;
    state_d.short_f = 1'b0;
    if (start_ev)
    begin
      // snapshot the whole reply so bytes and checksum agree
      state_d.tx = reply_w; // see [R06]
      state_d.miso = reply_w[acc_pkg::FRAME_BITS-1];
      state_d.bits = '0;
    end
    else if (sel && rise)
    begin
      // host bytes arrive in fixed order, MSB first
      state_d.rx = {state_q.rx[acc_pkg::FRAME_BITS-2:0],
        state_q.mosi_s}; // see [R01] [R02]
      if (state_q.bits != acc_pkg::BITCNT_W'(acc_pkg::FRAME_BITS))
      begin
        state_d.bits = state_q.bits + acc_pkg::BITCNT_W'(1);
      end
    end
    else if (sel && fall)
    begin
      state_d.tx = {state_q.tx[acc_pkg::FRAME_BITS-2:0], 1'b0};
      state_d.miso = state_q.tx[acc_pkg::FRAME_BITS-2];
    end
    else if (stop_ev)
    begin
      if (state_q.bits != acc_pkg::BITCNT_W'(acc_pkg::FRAME_BITS))
      begin
        // partial frame: dropped, nothing changes
        state_d.short_f = 1'b1;
      end
      else if (good_cks)
      begin
        state_d.cks_err = 1'b0; // see [R09]
        state_d.ok = 1'b1;
        if (cmd_legal)
        begin
          state_d.rtype = cmd_type; // see [R08]
          state_d.cbit = cmd_w[acc_pkg::CMD_CBIT]; // see [R05]
        end
      end
      else
      begin
        // bad checksum: type and self-test stay as before
        state_d.cks_err = 1'b1; // see [R13] [R09]
        state_d.bad = 1'b1;
      end
    end
  end

  // reset leaves the accel reply selected
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= STATE_RST; // see [R14]
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign link.miso_o = state_q.miso;
  assign link.miso_oe_n = state_q.ss_s;
  assign cbit_en = state_q.cbit;
  assign reply_type = state_q.rtype;
  assign frame_ok = state_q.ok;
  assign frame_bad = state_q.bad;
  assign frame_short = state_q.short_f;

endmodule

// *** rtl/acc_msg_host.sv ***
// Purpose: host controller that frames commands and collects replies
// Assumes: makes the link clock by dividing its own clock
// Notes: software drives it through a small register port
`timescale 1ns/1ps
module acc_msg_host
#(
  parameter int HALF_CYC = acc_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC = acc_pkg::FRAME_GAP_CYC
)
(
  input wire logic clock, // system clock
  input wire logic rst, // asynchronous reset, active high
  acc_link_if.host link, // serial link pins
  input wire logic [acc_pkg::ADDR_W-1:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic irq // level interrupt
);

  typedef enum logic [4:0] {
    IDLE = 5'b00001,
    LOW = 5'b00010,
    HIGH = 5'b00100,
    TRAIL = 5'b01000,
    GAP = 5'b10000
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [acc_pkg::CNT_W-1:0] cnt;
    logic [acc_pkg::BITCNT_W-1:0] bits;
    logic [acc_pkg::FRAME_BITS-1:0] tx;
    logic [acc_pkg::FRAME_BITS-1:0] rx;
    logic [acc_pkg::FRAME_BITS-1:0] reply;
    logic sclk;
    logic ss_n;
    logic mosi;
    logic miso_m;
    logic miso_s;
    logic [7:0] cmd;
    logic [acc_pkg::IRQ_W-1:0] irq_st;
    logic [acc_pkg::IRQ_W-1:0] mask;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    phase: IDLE,
    ss_n: 1'b1,
    cmd: {4'h0, acc_pkg::SEL_ACC},
    default: '0
  };
  localparam logic [acc_pkg::CNT_W-1:0] HALF_RLD =
    acc_pkg::CNT_W'(HALF_CYC - 1);
  localparam logic [acc_pkg::CNT_W-1:0] GAP_RLD =
    acc_pkg::CNT_W'(GAP_CYC - 1);

  state_t state_q;
  state_t state_d;
  logic [7:0] new_cmd;
  logic [39:0] body_w;
  logic sel_ok;
  logic [acc_pkg::IRQ_W-1:0] set_ev;

  assign new_cmd = wdata[7:0] & acc_pkg::CMD_KEEP; // see [R02] [R05]
  assign body_w = {new_cmd, {4{acc_pkg::ZERO_BYTE}}}; // see [R04]
  assign sel_ok = new_cmd[acc_pkg::SEL_MSB:0] == acc_pkg::SEL_ACC ||
    new_cmd[acc_pkg::SEL_MSB:0] == acc_pkg::SEL_STAT; // see [R03]

  always_comb
  begin
    state_d = state_q;
    set_ev = '0;
    state_d.miso_m = link.miso;
    state_d.miso_s = state_q.miso_m;
    if (state_q.cnt != '0)
    begin
      state_d.cnt = state_q.cnt - acc_pkg::CNT_W'(1);
    end
    case (state_q.phase)
      IDLE:
      begin
        if (wr && addr == acc_pkg::REG_CMD && wdata[acc_pkg::CMD_START])
        begin
          if (sel_ok)
          begin
            state_d.tx = {body_w, acc_pkg::frame_cks(body_w)};
            state_d.mosi = new_cmd[7];
            state_d.ss_n = 1'b0;
            state_d.bits = '0;
            state_d.cnt = HALF_RLD;
            state_d.phase = LOW;
          end
          else
          begin
            set_ev[acc_pkg::IRQ_REJ] = 1'b1;
          end
        end
      end
      LOW:
      begin
        if (state_q.cnt == '0)
        begin
          state_d.sclk = 1'b1;
          state_d.rx = {state_q.rx[acc_pkg::FRAME_BITS-2:0],
            state_q.miso_s};
          state_d.cnt = HALF_RLD;
          state_d.phase = HIGH;
        end
      end
      HIGH:
      begin
        if (state_q.cnt == '0)
        begin
          state_d.sclk = 1'b0;
          state_d.cnt = HALF_RLD;
          if (state_q.bits ==
            acc_pkg::BITCNT_W'(acc_pkg::FRAME_BITS - 1))
          begin
            state_d.phase = TRAIL; // see [R01]
          end
          else
          begin
            state_d.bits = state_q.bits + acc_pkg::BITCNT_W'(1);
            state_d.tx = {state_q.tx[acc_pkg::FRAME_BITS-2:0], 1'b0};
            state_d.mosi = state_q.tx[acc_pkg::FRAME_BITS-2];
            state_d.phase = LOW;
          end
        end
      end
      TRAIL:
      begin
        if (state_q.cnt == '0)
        begin
          state_d.ss_n = 1'b1;
          state_d.reply = state_q.rx;
          set_ev[acc_pkg::IRQ_DONE] = 1'b1;
          set_ev[acc_pkg::IRQ_CKS] =
            acc_pkg::frame_cks(state_q.rx[47:8]) != state_q.rx[7:0];
          state_d.cnt = GAP_RLD;
          state_d.phase = GAP;
        end
      end
      GAP:
      begin
        if (state_q.cnt == '0)
        begin
          state_d.phase = IDLE;
        end
      end
      default:
      begin
        state_d.phase = IDLE;
      end
    endcase
    if (wr)
    begin
      case (addr)
        acc_pkg::REG_CMD:
        begin
          if (state_q.phase == IDLE)
          begin
            state_d.cmd = new_cmd;
          end
        end
        acc_pkg::REG_IRQ:
        begin
          state_d.irq_st = state_q.irq_st & ~wdata[acc_pkg::IRQ_W-1:0];
        end
        acc_pkg::REG_MASK:
        begin
          state_d.mask = wdata[acc_pkg::IRQ_W-1:0];
        end
        default:
        begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    state_d.irq_st = state_d.irq_st | set_ev;
    state_d.rdata = '0;
    if (rd)
    begin
      case (addr)
        acc_pkg::REG_CMD:
        begin
          state_d.rdata[7:0] = state_q.cmd;
          state_d.rdata[acc_pkg::CMD_BUSY] = state_q.phase != IDLE;
        end
        acc_pkg::REG_IRQ:
        begin
          state_d.rdata[acc_pkg::IRQ_W-1:0] = state_q.irq_st;
        end
        acc_pkg::REG_MASK:
        begin
          state_d.rdata[acc_pkg::IRQ_W-1:0] = state_q.mask;
        end
        acc_pkg::REG_RPLY_HI:
        begin
          state_d.rdata = state_q.reply[47:16];
        end
        acc_pkg::REG_RPLY_LO:
        begin
          state_d.rdata[15:0] = state_q.reply[15:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= STATE_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign link.sclk = state_q.sclk;
  assign link.ss_n = state_q.ss_n;
  assign link.mosi = state_q.mosi;
  assign rdata = state_q.rdata;
  assign irq = |(state_q.irq_st & state_q.mask);

endmodule

// *** shared/acc_link_if.sv ***
// Purpose: serial link between host controller and sensor message handler
// Assumes: sensor releases its data line while deselected
// Notes: released data line reads high, as through a pull-up
`timescale 1ns/1ps
interface acc_link_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;

  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport dev (input sclk, ss_n, mosi, output miso_o, miso_oe_n);
  modport host (output sclk, ss_n, mosi, input miso);
endinterface

// *** shared/acc_pkg.sv ***
// Purpose: shared constants and helpers for the accelerometer serial link
// Assumes: six-byte frames, mode 0 serial clock, 125 MHz system clock
// Notes: host register map lives here as well
package acc_pkg;
  localparam int FRAME_BITS = 48;
  localparam int BITCNT_W = 6;
  localparam int CNT_W = 16;
  // command byte layout
  localparam int CMD_RSVD7 = 7;
  localparam int CMD_CBIT = 6;
  localparam int CMD_RSVD5 = 5;
  localparam int CMD_RSVD4 = 4;
  localparam int SEL_MSB = 3;
  localparam logic [3:0] SEL_ACC = 4'h1;
  localparam logic [3:0] SEL_STAT = 4'h2;
  localparam logic [7:0] CMD_KEEP = 8'h4f;
  // reply status byte layout
  localparam int ST_BIT_FAIL = 7;
  localparam int ST_Y_FAIL = 6;
  localparam int ST_X_FAIL = 5;
  localparam int ST_CKS_ERR = 4;
  localparam int ST_CBIT = 3;
  localparam int TYPE_MSB = 2;
  localparam logic [2:0] TYPE_ACC = 3'h1;
  localparam logic [2:0] TYPE_STAT = 3'h2;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 1000;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int MIN_FRAME_PERIOD_NS = 100000;
  localparam int FRAME_GAP_CYC =
    (MIN_FRAME_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host register map
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_IRQ = 5'h04;
  localparam logic [4:0] REG_MASK = 5'h08;
  localparam logic [4:0] REG_RPLY_HI = 5'h0c;
  localparam logic [4:0] REG_RPLY_LO = 5'h10;
  localparam int CMD_START = 8;
  localparam int CMD_BUSY = 9;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CKS = 1;
  localparam int IRQ_REJ = 2;

  // ones' complement of the byte sum of the first five bytes
  function automatic logic [7:0] frame_cks(input logic [39:0] b);
    logic [7:0] s;
    s = b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
    return ~s;
  endfunction
endpackage

// *** testbench/acc_link_chk.sv ***
// Purpose: watches the serial link between host end and sensor end
// Assumes: on this link every frame is made by the host end
// Notes: helper logic shifts both data lines at each link clock rise
`timescale 1ns/1ps
module acc_link_chk
(
  input wire logic clock, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic sclk, // link clock
  input wire logic ss_n, // select, active low
  input wire logic mosi, // host data
  input wire logic miso_oe_n, // device drives when low
  input wire logic miso // resolved device data
);
  logic sck_q;
  logic ss_q;
  logic [6:0] cnt_q;
  logic [47:0] mo_q;
  logic [47:0] mi_q;
  wire rise = sclk && !sck_q;
  wire done = ss_n && !ss_q;

  function automatic logic ck_ok(input logic [47:0] f);
    logic [7:0] s;
    s = f[47:40] + f[39:32] + f[31:24] + f[23:16] + f[15:8];
    return f[7:0] == ~s;
  endfunction

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      ss_q <= 1'b1;
      cnt_q <= 7'h00;
      mo_q <= 48'h0;
      mi_q <= 48'h0;
    end
    else
    begin
      sck_q <= sclk;
      ss_q <= ss_n;
      if (!ss_n && ss_q)
        cnt_q <= 7'h00;
      else if (rise)
      begin
        cnt_q <= cnt_q + 7'h01;
        mo_q <= {mo_q[46:0], mosi};
        mi_q <= {mi_q[46:0], miso};
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_sel;
    $fell(ss_n);
  endsequence
  sequence s_drive;
    !miso_oe_n [*3];
  endsequence

  AST_OE_ON: assert property (s_sel |-> ##[1:6] s_drive)
    else $error("device data line not driven after select");
  AST_OE_OFF: assert property
    ($rose(ss_n) |-> ##[1:6] miso_oe_n)
    else $error("device data line not released");
  AST_IDLE_CLK: assert property (ss_n |-> !sclk)
    else $error("link clock high while deselected");
  AST_MOSI_HOLD: assert property
    ((!ss_n && sclk) |-> $stable(mosi))
    else $error("host data moved while link clock high");
  AST_MISO_HOLD: assert property
    ((!miso_oe_n && sclk) |-> $stable(miso))
    else $error("device data moved while link clock high");
  AST_BITS: assert property (done |-> cnt_q == 7'h30)
    else $error("frame bit count wrong");
  AST_CMD_ZERO: assert property
    ((rise && (cnt_q == 7'h00 || cnt_q == 7'h02 || cnt_q == 7'h03))
      |-> !mosi)
    else $error("reserved command bit set");
  AST_DATA_ZERO: assert property
    ((rise && cnt_q >= 7'h08 && cnt_q < 7'h28) |-> !mosi)
    else $error("host data byte not zero");
  AST_TYPE_MSB: assert property
    ((rise && cnt_q == 7'h05) |-> !miso)
    else $error("reply type code out of range");
  AST_HOST_CKS: assert property (done |-> ck_ok(mo_q))
    else $error("host frame checksum wrong");
  AST_DEV_CKS: assert property (done |-> ck_ok(mi_q))
    else $error("reply frame checksum wrong");
endmodule

// *** testbench/accel_spi_message_handler_test.sv ***
// Purpose: self-checking bench for host and sensor ends of the link
// Assumes: second link is driven by the bench to inject bad frames
// Notes: expected replies are rebuilt from the bench's own state
`timescale 1ns/1ps
module accel_spi_message_handler_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [15:0] acc_y = 16'h0, acc_x = 16'h0, temp = 16'h0;
  logic [7:0] stat_aux = 8'h00;
  logic bit_fail = 1'b0, y_fail = 1'b0, x_fail = 1'b0;
  logic cb1, cb2;
  logic [2:0] rt1, rt2;
  logic [2:0] t1 = 3'h1, t2 = 3'h1;
  logic c1 = 1'b0, c2 = 1'b0, e2 = 1'b0;
  logic [31:0] d;
  logic [7:0] c;
  logic ok1, ok2, bad2, sh2;
  int n_ok1 = 0, n_ok2 = 0, n_bad2 = 0, n_sh2 = 0;
  int n_mismatch = 0;
  int checked = 0;
  acc_link_if link();
  acc_link_if link2();

  always #4 clock = ~clock;

  // frame verdict pulses counted for the scenarios
  always @(posedge clock)
  begin
    n_ok1 <= n_ok1 + int'(ok1);
    n_ok2 <= n_ok2 + int'(ok2);
    n_bad2 <= n_bad2 + int'(bad2);
    n_sh2 <= n_sh2 + int'(sh2);
  end

  acc_msg_host #(.HALF_CYC(8), .GAP_CYC(16)) acc_msg_host_inst (
    .clock(clock), .rst(rst), .link(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  acc_msg_device acc_msg_device_inst (
    .clock(clock), .rst(rst), .link(link), .acc_y(acc_y), .acc_x(acc_x),
    .temp(temp), .stat_aux(stat_aux), .bit_fail(bit_fail),
    .y_fail(y_fail), .x_fail(x_fail), .cbit_en(cb1), .reply_type(rt1),
    .frame_ok(ok1), .frame_bad(), .frame_short());
  acc_msg_device acc_msg_device_b_inst (
    .clock(clock), .rst(rst), .link(link2), .acc_y(acc_y), .acc_x(acc_x),
    .temp(temp), .stat_aux(stat_aux), .bit_fail(bit_fail),
    .y_fail(y_fail), .x_fail(x_fail), .cbit_en(cb2), .reply_type(rt2),
    .frame_ok(ok2), .frame_bad(bad2), .frame_short(sh2));
  acc_link_chk acc_link_chk_inst (
    .clock(clock), .rst(rst), .sclk(link.sclk), .ss_n(link.ss_n),
    .mosi(link.mosi), .miso_oe_n(link.miso_oe_n), .miso(link.miso));

  task chk(input string what, input logic [47:0] seen,
    input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task wr_reg(input logic [4:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  task rd_reg(input logic [4:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // whole reply frame the sensor owes for the given state
  function automatic logic [47:0] rep(input logic [2:0] t,
    input logic cb, input logic e);
    logic [39:0] b;
    logic [7:0] s;
    b[39:32] = {bit_fail, y_fail, x_fail, e, cb, t};
    b[31:0] = (t == 3'h1) ? {acc_y, acc_x} : {stat_aux, 8'h00, temp};
    s = b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
    return {b, ~s};
  endfunction

  task new_inputs;
    @(posedge clock);
    acc_y <= 16'($urandom);
    acc_x <= 16'($urandom);
    temp <= 16'($urandom);
    stat_aux <= 8'($urandom);
    {bit_fail, y_fail, x_fail} <= 3'($urandom);
  endtask

  task host_frame(input logic [7:0] cmd);
    logic [47:0] e;
    int i;
    int o;
    o = n_ok1;
    new_inputs();
    wr_reg(acc_pkg::REG_CMD, {23'h0, 1'b1, cmd});
    // a second start while the frame runs must be ignored
    wr_reg(acc_pkg::REG_CMD, 32'h142);
    e = rep(t1, c1, 1'b0);
    d = 32'h0;
    for (i = 0; i < 1000 && d[0] !== 1'b1; i++)
      rd_reg(acc_pkg::REG_IRQ, d);
    chk("irq status", d, 48'h1);
    chk("irq line", irq, 48'h1);
    rd_reg(acc_pkg::REG_RPLY_HI, d);
    chk("reply head", d, e[47:16]);
    rd_reg(acc_pkg::REG_RPLY_LO, d);
    chk("reply tail", d, {16'h0, e[15:0]});
    wr_reg(acc_pkg::REG_IRQ, 32'h7);
    chk("irq clear", irq, 48'h0);
    t1 = cmd[2:0];
    c1 = cmd[6];
    chk("reply type", rt1, t1);
    chk("self test", cb1, c1);
    chk("frame ok", 48'(n_ok1 - o), 48'h1);
    // force at least one status read, then wait for the gap to end
    d = 32'h200;
    for (i = 0; i < 100 && d[9] !== 1'b0; i++)
      rd_reg(acc_pkg::REG_CMD, d);
    chk("busy refuse", d, {24'h0, cmd});
  endtask

  // bench plays host on the second link; checksum may be spoiled and
  // the frame may be cut after 48 - lo bits
  task rogue(input logic [7:0] cmd, input logic bad, input int lo);
    logic [47:0] f, r, e;
    int k, o, b, s;
    f = {cmd, 32'h0, ~cmd ^ (bad ? 8'h5a : 8'h00)};
    r = '0;
    o = n_ok2;
    b = n_bad2;
    s = n_sh2;
    new_inputs();
    @(posedge clock);
    e = rep(t2, c2, e2);
    link2.ss_n <= 1'b0;
    link2.mosi <= f[47];
    // 160 ns link clock: ten system clocks per half
    for (k = 47; k >= lo; k--)
    begin
      repeat (10) @(posedge clock);
      link2.sclk <= 1'b1;
      r[k] = link2.miso;
      repeat (10) @(posedge clock);
      link2.sclk <= 1'b0;
      link2.mosi <= (k > lo) ? f[k-1] : 1'b1;
    end
    repeat (10) @(posedge clock);
    link2.ss_n <= 1'b1;
    repeat (50) @(posedge clock);
    chk("side reply", r >> lo, e >> lo);
    chk("side verdict",
      {16'(n_ok2 - o), 16'(n_bad2 - b), 16'(n_sh2 - s)},
      {16'(lo == 0 && !bad), 16'(lo == 0 && bad), 16'(lo != 0)});
    if (lo == 0)
    begin
      e2 = bad;
      if (!bad && cmd[7] == 1'b0 && cmd[5:4] == 2'h0 &&
        (cmd[3:0] == 4'h1 || cmd[3:0] == 4'h2))
      begin
        t2 = cmd[2:0];
        c2 = cmd[6];
      end
    end
    chk("side type", rt2, t2);
    chk("side test", cb2, c2);
  endtask

  initial
  begin
    link2.sclk = 1'b0;
    link2.ss_n = 1'b1;
    link2.mosi = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    void'($urandom(32'hba1bc1ff));
    repeat (5) @(posedge clock);
    rd_reg(5'h14, d);
    chk("unmapped", d, 48'h0);
    wr_reg(acc_pkg::REG_CMD, 32'hf1);
    rd_reg(acc_pkg::REG_CMD, d);
    chk("command store", d, 48'h41);
    wr_reg(acc_pkg::REG_CMD, 32'h103);
    rd_reg(acc_pkg::REG_IRQ, d);
    chk("refused", d, 48'h4);
    chk("no frame", link.ss_n, 48'h1);
    chk("masked", irq, 48'h0);
    wr_reg(acc_pkg::REG_MASK, 32'h4);
    chk("unmasked", irq, 48'h1);
    wr_reg(acc_pkg::REG_IRQ, 32'h7);
    chk("cleared", irq, 48'h0);
    wr_reg(acc_pkg::REG_MASK, 32'h1);
    foreach (c[k])
      if (k < 4)
        host_frame({1'b0, k[1], 4'h0, k[0] ? 2'h2 : 2'h1});
    repeat (6)
    begin
      c = {1'b0, 1'($urandom), 4'h0, ($urandom % 2) ? 2'h2 : 2'h1};
      host_frame(c);
    end
    rogue(8'h02, 1'b1, 0);
    rogue(8'h92, 1'b0, 0);
    rogue(8'h41, 1'b0, 8);
    rogue(8'h42, 1'b1, 0);
    rogue(8'h42, 1'b0, 0);
    for (int j = 0; j < 16; j++)
      rogue({1'b0, j[0], 2'h0, j[3:0]}, j == 9, 0);
    test_done();
  end

  initial
  begin
    // tests take about 250 us; give them 400 us
    #400000;
    n_mismatch++;
    test_done();
  end
endmodule
